// ### ssior_pkg.sv
// What this block does
// R1: error code register holds only 0 to 255
// R2: error code zero means scale has no error
// R3: status bit 0: net exceeds one register
// R4: status bit 1: gross exceeds one register
// R5: status bit 2: flow exceeds one register
// R6: bits 3,4,5: good zero display, gross, net
// R7: bit 6 one in net, zero gross
// R8: bit 11 set while flow rate displayed
// R9: bit 12 set when net exceeds six digits
// R10: bit 13 set when gross exceeds six digits
// R11: master trusts weights only with zero error
// R12: per scale input signal in mV/V readable
// R13: analog output registers rounded to thousandths
// R14: input word a: 11-18 low, 21-28 high
// R15: input word b: 31-38 low, 41-48 high
// R16: input word c: 51-58 low, 61-68 high
// R17: output word a: 11-18 low, 21-28 high
// R18: status bits 8,9,10,14,15 read zero
package ssior_pkg;
   localparam int          SCALE_COUNT      = 6;
   localparam int          AOUT_COUNT       = 4;
   localparam int          DIN_COUNT        = 48;
   localparam int          DOUT_COUNT       = 16;
   localparam int          WORD_W           = 16;
   localparam int          ADDR_W           = 16;
   localparam int          VALUE_W          = 32;
   localparam int          ERR_W            = 8;
   // register map, scale s at SCALE_BASE + s * SCALE_STRIDE
   localparam logic [15:0] SCALE_BASE       = 16'h0000;
   localparam logic [15:0] SCALE_STRIDE     = 16'h0010;
   localparam logic [3:0]  OFS_ERROR        = 4'h0;
   localparam logic [3:0]  OFS_STATUS       = 4'h1;
   localparam logic [3:0]  OFS_GROSS_HI     = 4'h2;
   localparam logic [3:0]  OFS_GROSS_LO     = 4'h3;
   localparam logic [3:0]  OFS_NET_HI       = 4'h4;
   localparam logic [3:0]  OFS_NET_LO       = 4'h5;
   localparam logic [3:0]  OFS_FLOW_HI      = 4'h6;
   localparam logic [3:0]  OFS_FLOW_LO      = 4'h7;
   localparam logic [3:0]  OFS_SIGNAL_HI    = 4'h8;
   localparam logic [3:0]  OFS_SIGNAL_LO    = 4'h9;
   localparam logic [15:0] AOUT_BASE        = 16'h0100;
   localparam logic [15:0] INPUT_STATUS_A   = 16'h0110;
   localparam logic [15:0] INPUT_STATUS_B   = 16'h0111;
   localparam logic [15:0] INPUT_STATUS_C   = 16'h0112;
   localparam logic [15:0] OUTPUT_STATUS_A  = 16'h0113;
   // scale status word bit positions
   localparam int          ST_NET_INT_OVF   = 0;
   localparam int          ST_GROSS_INT_OVF = 1;
   localparam int          ST_FLOW_INT_OVF  = 2;
   localparam int          ST_ZERO_DISP     = 3;
   localparam int          ST_ZERO_GROSS    = 4;
   localparam int          ST_ZERO_NET      = 5;
   localparam int          ST_NET_MODE      = 6;
   localparam int          ST_MOTION        = 7;
   localparam int          ST_FLOW_DISPLAY  = 11;
   localparam int          ST_NET_DIGITS    = 12;
   localparam int          ST_GROSS_DIGITS  = 13;
   // six-digit limit and rounding divisor for analog values
   localparam logic [31:0] DIGIT_LIMIT      = 32'h000F_423F;
   localparam logic [31:0] AOUT_HALF        = 32'h0000_0005;
   localparam logic [31:0] AOUT_DIV         = 32'h0000_000A;
   localparam logic [15:0] RESET_WORD       = 16'h0000;
   localparam logic [31:0] RESET_VALUE      = 32'h0000_0000;
endpackage

// ### ssior_regs.sv
`timescale 1ns/1ps
module ssior_regs (
   input  wire logic                                   core_clk,
   input  wire logic                                   rst_n,
   // per scale measurements from the weighing logic
   input  wire logic [ssior_pkg::SCALE_COUNT*8-1:0]    scale_error,
   input  wire logic [ssior_pkg::SCALE_COUNT*32-1:0]   scale_gross,
   input  wire logic [ssior_pkg::SCALE_COUNT*32-1:0]   scale_net,
   input  wire logic [ssior_pkg::SCALE_COUNT*32-1:0]   scale_flow,
   input  wire logic [ssior_pkg::SCALE_COUNT*32-1:0]   scale_signal,
   input  wire logic [ssior_pkg::SCALE_COUNT-1:0]      scale_zero_disp,
   input  wire logic [ssior_pkg::SCALE_COUNT-1:0]      scale_zero_gross,
   input  wire logic [ssior_pkg::SCALE_COUNT-1:0]      scale_zero_net,
   input  wire logic [ssior_pkg::SCALE_COUNT-1:0]      scale_net_mode,
   input  wire logic [ssior_pkg::SCALE_COUNT-1:0]      scale_motion,
   input  wire logic [ssior_pkg::SCALE_COUNT-1:0]      scale_flow_display,
   // analog drive values in ten-thousandths
   input  wire logic [ssior_pkg::AOUT_COUNT*32-1:0]    aout_value,
   // digital input pins and output drive levels
   input  wire logic [ssior_pkg::DIN_COUNT-1:0]        din_pin,
   input  wire logic [ssior_pkg::DOUT_COUNT-1:0]       dout_level,
   // register read port
   input  wire logic                                   rd_req,
   input  wire logic [ssior_pkg::ADDR_W-1:0]           rd_addr,
   output logic                                        rd_ack,
   output logic                                        rd_err,
   output logic      [ssior_pkg::WORD_W-1:0]           rd_data
);

   localparam int NS = ssior_pkg::SCALE_COUNT;
   localparam int NA = ssior_pkg::AOUT_COUNT;

   // true when a signed value does not fit one 16-bit register
   function automatic logic int_overflow(input logic [31:0] v);
      int_overflow = !((v[31:15] == 17'h0_0000) || (v[31:15] == 17'h1_FFFF));
   endfunction

   // true when the magnitude needs more than six digits
   function automatic logic over_digits(input logic [31:0] v);
      logic [31:0] mag;
      mag = v[31] ? (32'h0000_0000 - v) : v;
      over_digits = (mag > ssior_pkg::DIGIT_LIMIT);
   endfunction

   // round ten-thousandths to thousandths, half away from zero
   function automatic logic [31:0] round_milli(input logic [31:0] v);
      logic [31:0] mag;
      logic [31:0] q;
      mag = v[31] ? (32'h0000_0000 - v) : v;
      q = (mag + ssior_pkg::AOUT_HALF) / ssior_pkg::AOUT_DIV;
      round_milli = v[31] ? (32'h0000_0000 - q) : q;
   endfunction

   logic [15:0] err_q      [NS];
   logic [15:0] stat_q     [NS];
   logic [31:0] gross_q    [NS];
   logic [31:0] net_q      [NS];
   logic [31:0] flow_q     [NS];
   logic [31:0] signal_q   [NS];
   logic [15:0] next_err   [NS];
   logic [15:0] next_stat  [NS];
   logic [31:0] aout_q     [NA];
   logic [31:0] next_aout  [NA];

   // per scale status word and error code assembly
   genvar s;
   generate
      for (s = 0; s < NS; s++) begin : g_scale
         always_comb begin
            next_err[s] = {8'h00, scale_error[s*8 +: 8]}; // R1 R2
            next_stat[s] = ssior_pkg::RESET_WORD; // R18
            next_stat[s][ssior_pkg::ST_NET_INT_OVF] = int_overflow(scale_net[s*32 +: 32]); // R3
            next_stat[s][ssior_pkg::ST_GROSS_INT_OVF] = int_overflow(scale_gross[s*32 +: 32]); // R4
            next_stat[s][ssior_pkg::ST_FLOW_INT_OVF] = int_overflow(scale_flow[s*32 +: 32]); // R5
            next_stat[s][ssior_pkg::ST_ZERO_DISP] = scale_zero_disp[s]; // R6
            next_stat[s][ssior_pkg::ST_ZERO_GROSS] = scale_zero_gross[s]; // R6
            next_stat[s][ssior_pkg::ST_ZERO_NET] = scale_zero_net[s]; // R6
            next_stat[s][ssior_pkg::ST_NET_MODE] = scale_net_mode[s]; // R7
            next_stat[s][ssior_pkg::ST_MOTION] = scale_motion[s];
            next_stat[s][ssior_pkg::ST_FLOW_DISPLAY] = scale_flow_display[s]; // R8
            next_stat[s][ssior_pkg::ST_NET_DIGITS] = over_digits(scale_net[s*32 +: 32]); // R9
            next_stat[s][ssior_pkg::ST_GROSS_DIGITS] = over_digits(scale_gross[s*32 +: 32]); // R10
         end

         // snapshot of every scale value, one word set per cycle
         always_ff @(posedge core_clk) begin
            if (!rst_n) begin
               err_q[s]    <= ssior_pkg::RESET_WORD;
               stat_q[s]   <= ssior_pkg::RESET_WORD;
               gross_q[s]  <= ssior_pkg::RESET_VALUE;
               net_q[s]    <= ssior_pkg::RESET_VALUE;
               flow_q[s]   <= ssior_pkg::RESET_VALUE;
               signal_q[s] <= ssior_pkg::RESET_VALUE;
            end else begin
               err_q[s]    <= next_err[s];
               stat_q[s]   <= next_stat[s];
               gross_q[s]  <= scale_gross[s*32 +: 32];
               net_q[s]    <= scale_net[s*32 +: 32];
               flow_q[s]   <= scale_flow[s*32 +: 32];
               signal_q[s] <= scale_signal[s*32 +: 32]; // R12
            end
         end
      end
   endgenerate

   // analog output values rounded to thousandths
   genvar a;
   generate
      for (a = 0; a < NA; a++) begin : g_aout
         always_comb begin
            next_aout[a] = round_milli(aout_value[a*32 +: 32]); // R13
         end

         always_ff @(posedge core_clk) begin
            if (!rst_n) begin
               aout_q[a] <= ssior_pkg::RESET_VALUE;
            end else begin
               aout_q[a] <= next_aout[a];
            end
         end
      end
   endgenerate

   // two-stage synchroniser for input pins, output levels registered
   logic [47:0] din_meta;
   logic [47:0] din_sync;
   logic [15:0] dout_q;

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         din_meta <= 48'h0000_0000_0000;
         din_sync <= 48'h0000_0000_0000;
         dout_q   <= ssior_pkg::RESET_WORD;
      end else begin
         din_meta <= din_pin;
         din_sync <= din_meta;
         dout_q   <= dout_level;
      end
   end

   // read decode
   logic        next_ack;
   logic        next_err_flag;
   logic [15:0] next_data;
   logic [15:0] scale_rel;
   logic [15:0] aout_rel;
   int unsigned sidx;
   int unsigned aidx;

   always_comb begin
      next_ack      = rd_req;
      next_err_flag = 1'b0;
      next_data     = ssior_pkg::RESET_WORD;
      scale_rel     = rd_addr - ssior_pkg::SCALE_BASE;
      aout_rel      = rd_addr - ssior_pkg::AOUT_BASE;
      sidx          = 32'(scale_rel[15:4]);
      aidx          = 32'(aout_rel[15:1]);
      if (rd_req) begin
         if (rd_addr >= ssior_pkg::SCALE_BASE && sidx < NS) begin
            unique case (scale_rel[3:0])
               ssior_pkg::OFS_ERROR:     next_data = err_q[sidx]; // R1 R2
               ssior_pkg::OFS_STATUS:    next_data = stat_q[sidx];
               ssior_pkg::OFS_GROSS_HI:  next_data = gross_q[sidx][31:16];
               ssior_pkg::OFS_GROSS_LO:  next_data = gross_q[sidx][15:0];
               ssior_pkg::OFS_NET_HI:    next_data = net_q[sidx][31:16];
               ssior_pkg::OFS_NET_LO:    next_data = net_q[sidx][15:0];
               ssior_pkg::OFS_FLOW_HI:   next_data = flow_q[sidx][31:16];
               ssior_pkg::OFS_FLOW_LO:   next_data = flow_q[sidx][15:0];
               ssior_pkg::OFS_SIGNAL_HI: next_data = signal_q[sidx][31:16]; // R12
               ssior_pkg::OFS_SIGNAL_LO: next_data = signal_q[sidx][15:0]; // R12
               default:                  next_err_flag = 1'b1;
            endcase
         end else if (rd_addr >= ssior_pkg::AOUT_BASE && aidx < NA) begin
            next_data = aout_rel[0] ? aout_q[aidx][15:0] : aout_q[aidx][31:16]; // R13
         end else if (rd_addr == ssior_pkg::INPUT_STATUS_A) begin
            next_data = din_sync[15:0]; // R14
         end else if (rd_addr == ssior_pkg::INPUT_STATUS_B) begin
            next_data = din_sync[31:16]; // R15
         end else if (rd_addr == ssior_pkg::INPUT_STATUS_C) begin
            next_data = din_sync[47:32]; // R16
         end else if (rd_addr == ssior_pkg::OUTPUT_STATUS_A) begin
            next_data = dout_q; // R17
         end else begin
            next_err_flag = 1'b1;
         end
      end
   end

   // registered answer, one cycle after the request
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         rd_ack  <= 1'b0;
         rd_err  <= 1'b0;
         rd_data <= ssior_pkg::RESET_WORD;
      end else begin
         rd_ack  <= next_ack;
         rd_err  <= next_err_flag;
         rd_data <= next_data;
      end
   end

endmodule // ssior_regs

// ### ssior_sva.sv
`timescale 1ns/1ps
module ssior_sva (
   input wire logic                              core_clk,
   input wire logic                              rst_n,
   input wire logic [ssior_pkg::SCALE_COUNT-1:0] scale_net_mode,
   input wire logic [ssior_pkg::SCALE_COUNT-1:0] scale_flow_display,
   input wire logic                              rd_req,
   input wire logic [ssior_pkg::ADDR_W-1:0]      rd_addr,
   input wire logic                              rd_ack,
   input wire logic                              rd_err,
   input wire logic [ssior_pkg::WORD_W-1:0]      rd_data
);
   logic [5:0] nm_q, fd_q, next_nm_q, next_fd_q;
   logic       sa, st;
   // flag copy, cleared in reset like the register snapshot
   always_comb begin
      next_nm_q = rst_n ? scale_net_mode : 6'h00;
      next_fd_q = rst_n ? scale_flow_display : 6'h00;
   end
   always_ff @(posedge core_clk) begin
      nm_q <= next_nm_q;
      fd_q <= next_fd_q;
   end
   // scale region decode
   assign sa = rd_req && rd_addr < 16'h0060;
   assign st = sa && rd_addr[3:0] == 4'h1;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   ack_follows_a: assert property (rd_req |=> rd_ack) else $error("read not acknowledged");
   ack_idle_a: assert property (!rd_req |=> !rd_ack) else $error("ack without read");
   refuse_zero_a: assert property (rd_err |-> rd_ack && rd_data == 16'h0000) else $error("refusal carries data");
   unmapped_err_a: assert property (sa && rd_addr[3:0] > 4'h9 |=> rd_err) else $error("hole not refused");
   err_range_a: assert property (sa && rd_addr[3:0] == 4'h0 |=> rd_data[15:8] == 8'h00 && !rd_err)
      else $error("error code above 255");
   spare_bits_a: assert property (st |=> rd_data[10:8] == 3'b000 && rd_data[15:14] == 2'b00)
      else $error("spare status bit set");
   net_mode_a: assert property (st |=> rd_data[6] == $past(nm_q[rd_addr[6:4]]))
      else $error("net mode bit wrong");
   flow_disp_a: assert property (st |=> rd_data[11] == $past(fd_q[rd_addr[6:4]]))
      else $error("flow display bit wrong");
   cover property (st ##1 rd_data[6]);
   cover property (rd_ack && rd_err);
   cover property (st ##1 rd_data[11]);
endmodule // ssior_sva

bind ssior_regs ssior_sva ssior_sva_i (.core_clk(core_clk), .rst_n(rst_n), .scale_net_mode(scale_net_mode),
   .scale_flow_display(scale_flow_display), .rd_req(rd_req), .rd_addr(rd_addr), .rd_ack(rd_ack),
   .rd_err(rd_err), .rd_data(rd_data));

// ### ssior_master.sv
`timescale 1ns/1ps
module ssior_master (
   input  wire logic        core_clk,
   input  wire logic        rd_ack,
   input  wire logic        rd_err,
   input  wire logic [15:0] rd_data,
   output logic             rd_req = 1'b0,
   output logic      [15:0] rd_addr = 16'h0000
);
   // one read: request over one edge, answer taken mid-cycle while it stands
   task automatic rd(input logic [15:0] a, output logic [17:0] r);
      @(negedge core_clk);
      rd_req = 1'b1;
      rd_addr = a;
      @(negedge core_clk);
      r = {rd_ack, rd_err, rd_data}; // settled since the taking edge
      rd_req = 1'b0;
      rd_addr = ~a; // stale address is not left on the bus
   endtask
endmodule // ssior_master

// ### tb.sv
`timescale 1ns/1ps
module tb;
   localparam int          S = ssior_pkg::SCALE_COUNT;
   localparam logic [31:0] EDGE [8] = '{32'h0000_7FFF, 32'h0000_8000, 32'hFFFF_8000, 32'hFFFF_7FFF,
                                        32'h000F_423F, 32'h000F_4240, 32'hFFF0_BDC0, 32'hFFF0_BDC1};
   logic                   core_clk = 1'b0;
   logic                   rst_n = 1'b0;
   logic [S*8-1:0]         scale_error = '0;
   logic [S*32-1:0]        scale_gross = '0, scale_net = '0, scale_flow = '0, scale_signal = '0;
   logic [S-1:0]           zd = '0, zg = '0, zn = '0, nm = '0, mo = '0, fd = '0;
   logic [127:0]           aout_value = '0, rv;
   logic [47:0]            din_pin = '0;
   logic [15:0]            dout_level = '0, rd_addr, rd_data;
   logic                   rd_req, rd_ack, rd_err;
   logic [17:0]            r;
   integer                 seed = 32'h79ac_fc0b;
   int                     fail_count = 0, checks = 0;
   ssior_regs ssior_regs_i (.core_clk(core_clk), .rst_n(rst_n), .scale_error(scale_error),
      .scale_gross(scale_gross), .scale_net(scale_net), .scale_flow(scale_flow), .scale_signal(scale_signal),
      .scale_zero_disp(zd), .scale_zero_gross(zg), .scale_zero_net(zn), .scale_net_mode(nm),
      .scale_motion(mo), .scale_flow_display(fd), .aout_value(aout_value), .din_pin(din_pin),
      .dout_level(dout_level), .rd_req(rd_req), .rd_addr(rd_addr), .rd_ack(rd_ack), .rd_err(rd_err),
      .rd_data(rd_data));
   ssior_master ssior_master_i (.core_clk(core_clk), .rd_ack(rd_ack), .rd_err(rd_err), .rd_data(rd_data),
      .rd_req(rd_req), .rd_addr(rd_addr));
   // clock
   always #5 core_clk = ~core_clk;
   // expectation helpers
   function automatic logic ovf(logic signed [31:0] v);
      return v > 32767 || v < -32768;
   endfunction
   function automatic logic big(logic signed [31:0] v);
      return v > 999999 || v < -999999;
   endfunction
   function automatic logic [15:0] sts(int s);
      logic signed [31:0] g, n, f;
      g = scale_gross[s*32+:32];
      n = scale_net[s*32+:32];
      f = scale_flow[s*32+:32];
      return {2'b00, big(g), big(n), fd[s], 3'b000, mo[s], nm[s], zn[s], zg[s], zd[s],
              ovf(f), ovf(g), ovf(n)};
   endfunction
   function automatic logic [31:0] rnd(logic signed [31:0] v);
      logic [31:0] q;
      q = ($unsigned(v < 0 ? -v : v) + 32'd5) / 32'd10;
      return v < 0 ? -q : q;
   endfunction
   function automatic logic [17:0] exp(logic [15:0] a);
      logic [31:0] v [4];
      logic [31:0] w;
      int          s;
      s = a[6:4];
      v = '{scale_gross[s*32+:32], scale_net[s*32+:32], scale_flow[s*32+:32], scale_signal[s*32+:32]};
      w = rnd(aout_value[a[2:1]*32+:32]);
      if (a < 16'h0060 && a[3:0] == 4'h0) return {2'b10, 8'h00, scale_error[s*8+:8]};
      if (a < 16'h0060 && a[3:0] == 4'h1) return {2'b10, sts(s)};
      if (a < 16'h0060 && a[3:0] <= 4'h9) return {2'b10, a[0] ? v[a[3:1]-1][15:0] : v[a[3:1]-1][31:16]};
      if (a[15:3] == 13'h0020) return {2'b10, a[0] ? w[15:0] : w[31:16]};
      if (a[15:2] == 14'h0044) return {2'b10, a[1:0] == 2'b11 ? dout_level : din_pin[a[1:0]*16+:16]};
      return 18'h3_0000;
   endfunction
   // compare and count
   task automatic chk(logic [17:0] got, logic [17:0] want);
      checks++;
      if (got !== want) begin
         $display("MISMATCH t=%0t got %h want %h", $time, got, want);
         fail_count++;
      end
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // new random inputs with boundary values mixed in
   task automatic shake(int it);
      @(negedge core_clk);
      for (int k = 0; k < S; k++) begin
         scale_gross[k*32+:32] = it[0] ? EDGE[$random(seed) & 7] : $random(seed);
         scale_net[k*32+:32] = it[1] ? EDGE[$random(seed) & 7] : $random(seed);
         scale_flow[k*32+:32] = it[2] ? EDGE[$random(seed) & 7] : $random(seed) % 40000;
         scale_signal[k*32+:32] = $random(seed);
         scale_error[k*8+:8] = it[3] ? 8'($random(seed)) : 8'h00;
      end
      rv = {$random(seed), $random(seed), $random(seed), $random(seed)};
      {zd, zg, zn, nm, mo, fd} = rv[35:0];
      din_pin = rv[83:36];
      dout_level = rv[99:84];
      aout_value = {$random(seed), $random(seed), $random(seed), $random(seed)};
   endtask
   // main sequence: full map scan per input set
   initial begin
      repeat (16) @(negedge core_clk);
      rst_n = 1'b1;
      for (int it = 0; it < 16; it++) begin
         shake(it);
         repeat (4) @(negedge core_clk);
         for (int a = 0; a < 16'h0118; a++) begin
            ssior_master_i.rd(a[15:0], r);
            chk(r, exp(a[15:0]));
         end
         ssior_master_i.rd(16'hFFFF, r);
         chk(r, 18'h3_0000);
         $display("test %0d done", it);
      end
      conclude();
   end
   // watchdog
   initial begin
      repeat (20000) @(posedge core_clk);
      fail_count++;
      conclude();
   end
endmodule // tb
